// ### rtdcp_params.svh
// register numbers, field positions, reset values and decode figures of the channel bank
`ifndef RTDCP_PARAMS_SVH
`define RTDCP_PARAMS_SVH

// ==========================================================
// register numbers (bits 5..0 of the control byte)
`define RTDCP_REG_RAW_CONV        6'h00
`define RTDCP_REG_RAW_LINE        6'h01
`define RTDCP_REG_DIAG            6'h06
`define RTDCP_REG_COMMAND         6'h07
`define RTDCP_REG_IDENT           6'h08
`define RTDCP_REG_FW_VERSION      6'h09
`define RTDCP_REG_MIN_DATA_LEN    6'h0c
`define RTDCP_REG_HW_VERSION      6'h10
`define RTDCP_REG_VENDOR_OFS      6'h11
`define RTDCP_REG_VENDOR_GAIN     6'h12
`define RTDCP_REG_MAKER_OFS       6'h13
`define RTDCP_REG_MAKER_GAIN      6'h14
`define RTDCP_REG_TWO_WIRE        6'h15
`define RTDCP_REG_REF_OFS         6'h17
`define RTDCP_REG_REF_GAIN        6'h18
`define RTDCP_REG_CODE_WORD       6'h1f
`define RTDCP_REG_FEATURE         6'h20
`define RTDCP_REG_USER_OFS        6'h21
`define RTDCP_REG_USER_GAIN       6'h22
`define RTDCP_REG_FILTER          6'h25
`define RTDCP_REG_ELEMENT         6'h27
`define RTDCP_REG_CONV_TIME       6'h28

// ==========================================================
// control byte fields
`define RTDCP_CTRL_REG_BIT        7
`define RTDCP_CTRL_WR_BIT         6
`define RTDCP_CTRL_WR_MASK        8'h40

// ==========================================================
// fixed words and reset values
`define RTDCP_UNLOCK_WORD         16'h1235
`define RTDCP_FW_VERSION          16'h3141
`define RTDCP_MIN_DATA_LEN        16'h0098
`define RTDCP_FEATURE_WR_MASK     16'hf803
`define RTDCP_DEF_ZERO            16'h0000
`define RTDCP_DEF_GAIN            16'h0100
`define RTDCP_DEF_CONV_TIME       16'h000a
`define RTDCP_GAIN_FRAC_BITS      8

// ==========================================================
// feature field positions
`define RTDCP_FEAT_CURVE_HI       15
`define RTDCP_FEAT_CURVE_LO       12
`define RTDCP_FEAT_OFF_BIT        11
`define RTDCP_FEAT_MAKER_BIT      1
`define RTDCP_FEAT_USER_BIT       0

// ==========================================================
// filter constant codes and conversion times in ms
`define RTDCP_FILT_0              16'h0000
`define RTDCP_FILT_65             16'h0050
`define RTDCP_FILT_125            16'h00a0
`define RTDCP_FILT_250            16'h0140
`define RTDCP_FILT_500            16'h0280
`define RTDCP_MS_65               10'd65
`define RTDCP_MS_125              10'd125
`define RTDCP_MS_250              10'd250
`define RTDCP_MS_500              10'd500
`define RTDCP_MS_SLOW             10'd1000

`endif

// ### rtdcp_pkg.sv
// types shared by the channel parameter bank and its users
package rtdcp_pkg;

   // ==========================================================
   // register request from the coupler: control byte and output word
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [15:0] data;
   } rtdcp_req_s;

   // answer to the coupler: status byte and input word
   typedef struct packed {
      logic [7:0]  status;
      logic [15:0] data;
   } rtdcp_rsp_s;

   // ==========================================================
   // decoded feature settings of one channel
   typedef struct packed {
      logic [3:0] sensor_curve_select;
      logic       channel_off;
      logic       maker_scale_enable;
      logic       user_scale_enable;
   } rtdcp_feat_s;

   // storage slots of the writable registers other than the code word
   typedef enum logic [3:0] {
      SLOT_VENDOR_OFS,
      SLOT_VENDOR_GAIN,
      SLOT_MAKER_OFS,
      SLOT_MAKER_GAIN,
      SLOT_TWO_WIRE,
      SLOT_REF_OFS,
      SLOT_REF_GAIN,
      SLOT_FEATURE,
      SLOT_USER_OFS,
      SLOT_USER_GAIN,
      SLOT_FILTER,
      SLOT_ELEMENT,
      SLOT_CONV_TIME,
      SLOT_NONE
   } rtdcp_slot_e;

endpackage : rtdcp_pkg

// ### rtdcp_bank.sv
// eight-channel parameter register bank with code-word protection and persistent copy
`timescale 1ns/1ns
`include "rtdcp_params.svh"

module rtdcp_bank #(
   parameter int          NCH        = 8,
   parameter logic [15:0] IDENT_CODE = 16'h0abc,  // arbitrary value
   parameter logic [15:0] HW_VERSION = 16'h0000
) (
   // clock and resets
   input  wire logic                             sys_clk_in,
   input  wire logic                             rst_b_in,
   input  wire logic                             por_b_in,
   // coupler side, one request and one answer per channel
   input  wire logic [NCH-1:0]                   frame_valid_in,
   input  wire rtdcp_pkg::rtdcp_req_s [NCH-1:0]  req_in,
   output rtdcp_pkg::rtdcp_rsp_s [NCH-1:0]       rsp_out,
   output logic [NCH-1:0]                        rsp_valid_out,
   // converter side
   input  wire logic [NCH-1:0][15:0]             raw_conv_in,
   input  wire logic [NCH-1:0][15:0]             raw_line_in,
   input  wire logic [NCH-1:0][7:0]              channel_status_byte_in,
   // settings towards the measuring logic
   output rtdcp_pkg::rtdcp_feat_s [NCH-1:0]      feature_out,
   output logic [NCH-1:0][15:0]                  element_select_out,
   output logic [NCH-1:0][9:0]                   conv_ms_out,
   output logic [15:0]                           conv_time_setting_out,
   output logic                                  slow_conv_out,
   output logic [NCH-1:0]                        unlocked_out
);

   localparam int NSLOT = 13;

   // ==========================================================
   // functions
   function automatic rtdcp_pkg::rtdcp_slot_e slot_of(input logic [5:0] a);
      unique case (a)
         `RTDCP_REG_VENDOR_OFS:  slot_of = rtdcp_pkg::SLOT_VENDOR_OFS;
         `RTDCP_REG_VENDOR_GAIN: slot_of = rtdcp_pkg::SLOT_VENDOR_GAIN;
         `RTDCP_REG_MAKER_OFS:   slot_of = rtdcp_pkg::SLOT_MAKER_OFS;
         `RTDCP_REG_MAKER_GAIN:  slot_of = rtdcp_pkg::SLOT_MAKER_GAIN;
         `RTDCP_REG_TWO_WIRE:    slot_of = rtdcp_pkg::SLOT_TWO_WIRE;
         `RTDCP_REG_REF_OFS:     slot_of = rtdcp_pkg::SLOT_REF_OFS;
         `RTDCP_REG_REF_GAIN:    slot_of = rtdcp_pkg::SLOT_REF_GAIN;
         `RTDCP_REG_FEATURE:     slot_of = rtdcp_pkg::SLOT_FEATURE;
         `RTDCP_REG_USER_OFS:    slot_of = rtdcp_pkg::SLOT_USER_OFS;
         `RTDCP_REG_USER_GAIN:   slot_of = rtdcp_pkg::SLOT_USER_GAIN;
         `RTDCP_REG_FILTER:      slot_of = rtdcp_pkg::SLOT_FILTER;
         `RTDCP_REG_ELEMENT:     slot_of = rtdcp_pkg::SLOT_ELEMENT;
         `RTDCP_REG_CONV_TIME:   slot_of = rtdcp_pkg::SLOT_CONV_TIME;
         default:                slot_of = rtdcp_pkg::SLOT_NONE;
      endcase
   endfunction : slot_of

   function automatic logic [15:0] slot_default(input int s);
      if (s == int'(rtdcp_pkg::SLOT_VENDOR_GAIN) || s == int'(rtdcp_pkg::SLOT_MAKER_GAIN) ||
          s == int'(rtdcp_pkg::SLOT_REF_GAIN) || s == int'(rtdcp_pkg::SLOT_USER_GAIN)) begin
         slot_default = `RTDCP_DEF_GAIN;
      end else if (s == int'(rtdcp_pkg::SLOT_CONV_TIME)) begin
         slot_default = `RTDCP_DEF_CONV_TIME;
      end else begin
         slot_default = `RTDCP_DEF_ZERO;
      end
   endfunction : slot_default

   function automatic logic [15:0] slot_mask(input rtdcp_pkg::rtdcp_slot_e s);
      // reserved feature bits keep their stored zero
      slot_mask = (s == rtdcp_pkg::SLOT_FEATURE) ? `RTDCP_FEATURE_WR_MASK : 16'hffff;
   endfunction : slot_mask

   // gain is fixed point with 8 fraction bits; the sum wraps, no saturation
   function automatic logic [15:0] scale(input logic [15:0] x, input logic [15:0] gain,
                                         input logic [15:0] ofs);
      logic signed [31:0] prod;
      prod  = $signed(x) * $signed(gain);
      prod  = prod >>> `RTDCP_GAIN_FRAC_BITS;
      scale = 16'(prod[15:0] + ofs);
   endfunction : scale

   function automatic logic [9:0] filt_ms(input logic [15:0] f);
      unique case (f)
         `RTDCP_FILT_65:  filt_ms = `RTDCP_MS_65;
         `RTDCP_FILT_125: filt_ms = `RTDCP_MS_125;
         `RTDCP_FILT_500: filt_ms = `RTDCP_MS_500;
         // 0000, 0140 and undefined codes all run at 250 ms
         default:         filt_ms = `RTDCP_MS_250;
      endcase
   endfunction : filt_ms

   function automatic logic code_open(input logic [15:0] w);
      code_open = (w == `RTDCP_UNLOCK_WORD);
   endfunction : code_open

   // ==========================================================
   // storage
   logic [15:0] work_ff [NCH][NSLOT];
   logic [15:0] nv_ff   [NCH][NSLOT];
   logic [15:0] code_ff [NCH];
   logic        restore_ff;
   logic [15:0] proc_ff [NCH];

   logic [NCH-1:0]                        take;
   logic [NCH-1:0]                        wr_hit;
   logic [NCH-1:0]                        wr_ok;
   rtdcp_pkg::rtdcp_slot_e [NCH-1:0]      wr_slot;
   rtdcp_pkg::rtdcp_rsp_s [NCH-1:0]       nxt_rsp;
   logic [NCH-1:0][15:0]                  rd_val;
   logic [NCH-1:0][15:0]                  nxt_proc;
   logic                                  any_element;

   // ==========================================================
   // request decode
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         take[c]    = frame_valid_in[c] & ~restore_ff;
         wr_hit[c]  = take[c] & req_in[c].ctrl[`RTDCP_CTRL_REG_BIT]
                      & req_in[c].ctrl[`RTDCP_CTRL_WR_BIT];
         wr_slot[c] = slot_of(req_in[c].ctrl[5:0]);
         wr_ok[c]   = wr_hit[c] && (wr_slot[c] != rtdcp_pkg::SLOT_NONE)
                      && code_open(code_ff[c]);
      end
   end

   // ==========================================================
   // read multiplexer
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         rtdcp_pkg::rtdcp_slot_e s;
         s = slot_of(req_in[c].ctrl[5:0]);
         unique case (req_in[c].ctrl[5:0])
            `RTDCP_REG_RAW_CONV:     rd_val[c] = raw_conv_in[c];
            `RTDCP_REG_RAW_LINE:     rd_val[c] = raw_line_in[c];
            `RTDCP_REG_DIAG:         rd_val[c] = {8'h00, channel_status_byte_in[c]};
            `RTDCP_REG_COMMAND:      rd_val[c] = 16'h0000;
            `RTDCP_REG_IDENT:        rd_val[c] = IDENT_CODE;
            `RTDCP_REG_FW_VERSION:   rd_val[c] = `RTDCP_FW_VERSION;
            `RTDCP_REG_MIN_DATA_LEN: rd_val[c] = `RTDCP_MIN_DATA_LEN;
            `RTDCP_REG_HW_VERSION:   rd_val[c] = HW_VERSION;
            `RTDCP_REG_CODE_WORD:    rd_val[c] = code_ff[c];
            default: begin
               rd_val[c] = (s == rtdcp_pkg::SLOT_NONE) ? 16'h0000 : work_ff[c][s];
            end
         endcase
      end
   end

   // ==========================================================
   // answer
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         if (req_in[c].ctrl[`RTDCP_CTRL_REG_BIT]) begin
            if (req_in[c].ctrl[`RTDCP_CTRL_WR_BIT]) begin
               // the word returned after a write carries no meaning
               nxt_rsp[c].status = req_in[c].ctrl & ~`RTDCP_CTRL_WR_MASK;
               nxt_rsp[c].data   = 16'h0000;
            end else begin
               nxt_rsp[c].status = req_in[c].ctrl;
               nxt_rsp[c].data   = rd_val[c];
            end
         end else begin
            nxt_rsp[c].status = channel_status_byte_in[c];
            nxt_rsp[c].data   = proc_ff[c];
         end
      end
   end

   // answer word holds until the next taken frame
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rsp_out <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (take[c]) begin
               rsp_out[c] <= nxt_rsp[c];
            end
         end
      end
   end

   // one-cycle answer strobe
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rsp_valid_out <= '0;
      end else begin
         rsp_valid_out <= take;
      end
   end

   // ==========================================================
   // code word: always writable, never persistent
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int c = 0; c < NCH; c++) begin
            code_ff[c] <= 16'h0000;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (wr_hit[c] && req_in[c].ctrl[5:0] == `RTDCP_REG_CODE_WORD) begin
               code_ff[c] <= req_in[c].data;
            end
         end
      end
   end

   // ==========================================================
   // restore: one cycle after restart the working copy reloads from the persistent one
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         restore_ff <= 1'b1;
      end else begin
         restore_ff <= 1'b0;
      end
   end

   // ==========================================================
   // working copy
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int c = 0; c < NCH; c++) begin
            for (int s = 0; s < NSLOT; s++) begin
               work_ff[c][s] <= slot_default(s);
            end
         end
      end else if (restore_ff) begin
         for (int c = 0; c < NCH; c++) begin
            for (int s = 0; s < NSLOT; s++) begin
               work_ff[c][s] <= nv_ff[c][s];
            end
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (wr_ok[c]) begin
               work_ff[c][wr_slot[c]] <= (work_ff[c][wr_slot[c]] & ~slot_mask(wr_slot[c]))
                                         | (req_in[c].data & slot_mask(wr_slot[c]));
            end
         end
      end
   end

   // ==========================================================
   // persistent copy: set to the slot defaults only at power-on, survives restart
   always_ff @(posedge sys_clk_in or negedge por_b_in) begin
      if (!por_b_in) begin
         for (int c = 0; c < NCH; c++) begin
            for (int s = 0; s < NSLOT; s++) begin
               nv_ff[c][s] <= slot_default(s);
            end
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (wr_ok[c]) begin
               nv_ff[c][wr_slot[c]] <= (work_ff[c][wr_slot[c]] & ~slot_mask(wr_slot[c]))
                                       | (req_in[c].data & slot_mask(wr_slot[c]));
            end
         end
      end
   end

   // ==========================================================
   // measured value: maker scaling then user scaling
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         logic [15:0] feat;
         logic [15:0] v;
         feat = work_ff[c][rtdcp_pkg::SLOT_FEATURE];
         v    = raw_conv_in[c];
         if (feat[`RTDCP_FEAT_MAKER_BIT]) begin
            v = scale(v, work_ff[c][rtdcp_pkg::SLOT_MAKER_GAIN],
                      work_ff[c][rtdcp_pkg::SLOT_MAKER_OFS]);
         end
         if (feat[`RTDCP_FEAT_USER_BIT]) begin
            v = scale(v, work_ff[c][rtdcp_pkg::SLOT_USER_GAIN],
                      work_ff[c][rtdcp_pkg::SLOT_USER_OFS]);
         end
         // a switched-off channel reports zero rather than stale data
         nxt_proc[c] = feat[`RTDCP_FEAT_OFF_BIT] ? 16'h0000 : v;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int c = 0; c < NCH; c++) begin
            proc_ff[c] <= 16'h0000;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            proc_ff[c] <= nxt_proc[c];
         end
      end
   end

   // ==========================================================
   // settings towards the measuring logic
   always_comb begin
      any_element = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         any_element = any_element | (work_ff[c][rtdcp_pkg::SLOT_ELEMENT] != 16'h0000);
      end
   end

   // feature fields of every channel
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         feature_out <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            feature_out[c].sensor_curve_select <=
               work_ff[c][rtdcp_pkg::SLOT_FEATURE][`RTDCP_FEAT_CURVE_HI:`RTDCP_FEAT_CURVE_LO];
            feature_out[c].channel_off <=
               work_ff[c][rtdcp_pkg::SLOT_FEATURE][`RTDCP_FEAT_OFF_BIT];
            feature_out[c].maker_scale_enable <=
               work_ff[c][rtdcp_pkg::SLOT_FEATURE][`RTDCP_FEAT_MAKER_BIT];
            feature_out[c].user_scale_enable <=
               work_ff[c][rtdcp_pkg::SLOT_FEATURE][`RTDCP_FEAT_USER_BIT];
         end
      end
   end

   // conversion settings; one nonzero selector slows every channel
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         element_select_out    <= '0;
         conv_ms_out           <= '0;
         conv_time_setting_out <= `RTDCP_DEF_CONV_TIME;
         slow_conv_out         <= 1'b0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            element_select_out[c] <= work_ff[c][rtdcp_pkg::SLOT_ELEMENT];
            conv_ms_out[c] <= any_element ? `RTDCP_MS_SLOW
                              : filt_ms(work_ff[c][rtdcp_pkg::SLOT_FILTER]);
         end
         conv_time_setting_out <= work_ff[0][rtdcp_pkg::SLOT_CONV_TIME];
         slow_conv_out         <= any_element;
      end
   end

   // lock state as seen by the measuring logic
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         unlocked_out <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            unlocked_out[c] <= code_open(code_ff[c]);
         end
      end
   end

endmodule : rtdcp_bank

// ### rtdcp_coupler.sv
// behavioural fieldbus coupler doing register communication with the bank
`timescale 1ns/1ns
module rtdcp_coupler #(
   parameter int NCH = 8
) (
   // clock
   input  wire logic                             sys_clk_in,
   // towards the bank
   output logic [NCH-1:0]                        frame_valid_out,
   output rtdcp_pkg::rtdcp_req_s [NCH-1:0]       req_out,
   input  wire logic [NCH-1:0]                   rsp_valid_in,
   input  wire rtdcp_pkg::rtdcp_rsp_s [NCH-1:0]  rsp_in
);
   initial begin
      frame_valid_out = '0;
      req_out = '0;
   end
   // ==========================================================
   // one frame; gap idle cycles model a slow coupler
   task automatic xfer(input int ch, input logic [7:0] ctrl, input logic [15:0] data,
                       input int gap, output rtdcp_pkg::rtdcp_rsp_s rsp, output logic got);
      repeat (gap) @(posedge sys_clk_in);
      @(posedge sys_clk_in);
      frame_valid_out[ch] <= 1'b1;
      req_out[ch] <= {ctrl, data};
      @(posedge sys_clk_in);
      frame_valid_out[ch] <= 1'b0;
      // a released word never keeps showing the last value
      req_out[ch] <= ~{ctrl, data};
      #1;
      got = rsp_valid_in[ch];
      rsp = rsp_in[ch];
   endtask : xfer
endmodule : rtdcp_coupler

// ### rtdcp_bank_assertions.sv
// checker for the channel parameter bank, watching channel 0
`timescale 1ns/1ns
module rtdcp_bank_chk #(
   parameter int NCH = 8
) (
   input wire logic                             sys_clk_in,
   input wire logic                             rst_b_in,
   input wire logic [NCH-1:0]                   frame_valid_in,
   input wire rtdcp_pkg::rtdcp_req_s [NCH-1:0]  req_in,
   input wire rtdcp_pkg::rtdcp_rsp_s [NCH-1:0]  rsp_out,
   input wire logic [NCH-1:0]                   rsp_valid_out,
   input wire logic [NCH-1:0][15:0]             raw_conv_in,
   input wire logic [NCH-1:0][7:0]              channel_status_byte_in,
   input wire logic [NCH-1:0][9:0]              conv_ms_out,
   input wire logic                             slow_conv_out,
   input wire logic [NCH-1:0]                   unlocked_out
);
   logic       wr0;
   logic       rd0;
   logic [5:0] a0;
   assign a0 = req_in[0].ctrl[5:0];
   assign wr0 = frame_valid_in[0] && req_in[0].ctrl[7:6] == 2'b11;
   assign rd0 = frame_valid_in[0] && req_in[0].ctrl[7:6] == 2'b10;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   // ==========================================================
   // frames taken after the restore cycle are answered on the next edge
   a_frame_answered: assert property (frame_valid_in[0] && $past(rst_b_in) |=> rsp_valid_out[0])
      else $error("frame not answered");
   a_answer_cause: assert property (rsp_valid_out[0] |-> $past(frame_valid_in[0]))
      else $error("answer without frame");
   a_write_echo: assert property (wr0 && $past(rst_b_in) |=> rsp_out[0].status ==
      ($past(req_in[0].ctrl) & 8'hbf) && rsp_out[0].data == 16'h0000) else $error("bad write echo");
   a_read_echo: assert property (rd0 && $past(rst_b_in) |=> rsp_out[0].status == $past(req_in[0].ctrl))
      else $error("bad read echo");
   a_fw_fixed: assert property (rd0 && a0 == 6'h09 && $past(rst_b_in) |=> rsp_out[0].data == 16'h3141)
      else $error("bad firmware word");
   a_len_fixed: assert property (rd0 && a0 == 6'h0c && $past(rst_b_in) |=> rsp_out[0].data == 16'h0098)
      else $error("bad data length word");
   a_raw_passes: assert property (rd0 && a0 == 6'h00 && $past(rst_b_in) |=>
      rsp_out[0].data == $past(raw_conv_in[0])) else $error("raw value altered");
   a_diag_mirror: assert property (rd0 && a0 == 6'h06 && $past(rst_b_in) |=>
      rsp_out[0].data[7:0] == $past(channel_status_byte_in[0])) else $error("bad diagnostic byte");
   a_unlock_code: assert property (wr0 && a0 == 6'h1f && $past(rst_b_in) |=> ##1
      unlocked_out[0] == ($past(req_in[0].data, 2) == 16'h1235)) else $error("bad lock state");
   a_slow_all: assert property (slow_conv_out |-> conv_ms_out[0] == 10'd1000)
      else $error("slow conversion not applied");
   c_write: cover property (wr0 ##1 rsp_valid_out[0]);
   c_read_fw: cover property (rd0 && a0 == 6'h09);
   c_slow: cover property (slow_conv_out);
endmodule : rtdcp_bank_chk

bind rtdcp_bank rtdcp_bank_chk #(.NCH(NCH)) u_rtdcp_bank_chk (.sys_clk_in, .rst_b_in,
   .frame_valid_in, .req_in, .rsp_out, .rsp_valid_out, .raw_conv_in, .channel_status_byte_in,
   .conv_ms_out, .slow_conv_out, .unlocked_out);

// ### rtdcp_bank_test.sv
// self-checking bench for the channel parameter bank
`timescale 1ns/1ns
module rtdcp_bank_test;
   logic                              sys_clk_in, rst_b_in, por_b_in;
   logic [7:0]                        frame_valid_in, rsp_valid_out, unlocked_out;
   rtdcp_pkg::rtdcp_req_s [7:0]       req_in;
   rtdcp_pkg::rtdcp_rsp_s [7:0]       rsp_out;
   rtdcp_pkg::rtdcp_feat_s [7:0]      feature_out;
   logic [7:0][15:0]                  raw_conv_in, raw_line_in, element_select_out;
   logic [15:0]                       conv_time_setting_out;
   logic [7:0][7:0]                   channel_status_byte_in;
   logic [7:0][9:0]                   conv_ms_out;
   logic                              slow_conv_out, g;
   rtdcp_pkg::rtdcp_rsp_s             r;
   int                                mismatches, checked, cyc;
   logic [15:0]                       fc[5] = '{16'h0000, 16'h0050, 16'h00a0, 16'h0140, 16'h0280};
   logic [15:0]                       fm[5] = '{16'd250, 16'd65, 16'd125, 16'd250, 16'd500};

   // ident value is arbitrary
   rtdcp_bank #(.IDENT_CODE(16'h0123)) u_rtdcp_bank (.sys_clk_in, .rst_b_in, .por_b_in,
      .frame_valid_in, .req_in, .rsp_out, .rsp_valid_out, .raw_conv_in, .raw_line_in,
      .channel_status_byte_in, .feature_out, .element_select_out, .conv_ms_out,
      .conv_time_setting_out, .slow_conv_out, .unlocked_out);
   rtdcp_coupler u_rtdcp_coupler (.sys_clk_in, .frame_valid_out(frame_valid_in),
      .req_out(req_in), .rsp_valid_in(rsp_valid_out), .rsp_in(rsp_out));

   always #25 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         final_report();
      end
   end
   // ==========================================================
   task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t word %h expected %h", $time, got, exp);
      end
   endtask : chkw
   task automatic chkb(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t byte %h expected %h", $time, got, exp);
      end
   endtask : chkb
   task automatic rd(input int ch, input logic [5:0] a, input logic [15:0] exp);
      u_rtdcp_coupler.xfer(ch, {2'b10, a}, 16'h0000, 0, r, g);
      chkw({15'h0, g}, 16'h0001);
      chkb(r.status, {2'b10, a});
      chkw(r.data, exp);
   endtask : rd
   task automatic wr(input int ch, input logic [5:0] a, input logic [15:0] d);
      u_rtdcp_coupler.xfer(ch, {2'b11, a}, d, 1, r, g);
      chkb(r.status, {2'b10, a});
   endtask : wr
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic restart();
      @(posedge sys_clk_in) rst_b_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      por_b_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
   endtask : restart
   // ==========================================================
   initial begin
      {sys_clk_in, rst_b_in, por_b_in, mismatches, checked, cyc} = '0;
      for (int i = 0; i < 8; i++) begin
         raw_conv_in[i] = 16'h0200 + 16'(i);
         raw_line_in[i] = 16'h0040 + 16'(i);
         channel_status_byte_in[i] = 8'h10 + 8'(i);
      end
      restart();
      foreach (fc[i]) begin
         automatic int c = i * 7 / 4;
         rd(c, 6'h09, 16'h3141);
         rd(c, 6'h0c, 16'h0098);
         rd(c, 6'h08, 16'h0123);
         rd(c, 6'h07, 16'h0000);
         rd(c, 6'h00, 16'h0200 + 16'(c));
         rd(c, 6'h01, 16'h0040 + 16'(c));
         rd(c, 6'h12, 16'h0100);
         rd(c, 6'h20, 16'h0000);
         rd(c, 6'h27, 16'h0000);
         u_rtdcp_coupler.xfer(c, 8'h86, 16'h0000, 0, r, g);
         chkb(r.data[7:0], 8'h10 + 8'(c));
      end
      $display("test fixed words done");
      wr(0, 6'h20, 16'h0002);
      rd(0, 6'h20, 16'h0000);
      wr(0, 6'h1f, 16'h1235);
      rd(0, 6'h1f, 16'h1235);
      wr(0, 6'h09, 16'hffff);
      rd(0, 6'h09, 16'h3141);
      wr(0, 6'h20, 16'hffff);
      rd(0, 6'h20, 16'hf803);
      chkw({9'h0, feature_out[0]}, 16'h007f);
      wr(5, 6'h20, 16'h0002);
      rd(5, 6'h20, 16'h0000);
      wr(0, 6'h15, 16'h0033);
      rd(0, 6'h15, 16'h0033);
      $display("test lock done");
      wr(0, 6'h13, 16'h0005);
      wr(0, 6'h21, 16'h0003);
      foreach (fm[i]) begin
         wr(0, 6'h20, 16'(i % 3));
         u_rtdcp_coupler.xfer(0, 8'h00, 16'h0000, 2, r, g);
         chkw(r.data, 16'h0200 + (i % 3 == 2 ? 16'h0005 : 16'(i % 3 * 3)));
         chkb(r.status, 8'h10);
         wr(0, 6'h25, fc[i]);
         repeat (2) @(posedge sys_clk_in);
         #1 chkw({6'h0, conv_ms_out[0]}, fm[i]);
      end
      $display("test scaling and filter done");
      wr(3, 6'h1f, 16'h1235);
      wr(3, 6'h27, 16'h00c8);
      wr(0, 6'h28, 16'h0014);
      wr(3, 6'h28, 16'h0030);
      repeat (2) @(posedge sys_clk_in);
      #1 chkw({15'h0, slow_conv_out}, 16'h0001);
      chkw({6'h0, conv_ms_out[0]}, 16'd1000);
      chkw(element_select_out[3], 16'h00c8);
      chkw(conv_time_setting_out, 16'h0014);
      wr(3, 6'h27, 16'h0000);
      $display("test element done");
      restart();
      rd(0, 6'h15, 16'h0033);
      rd(0, 6'h1f, 16'h0000);
      wr(0, 6'h15, 16'h0044);
      rd(0, 6'h15, 16'h0033);
      $display("test restart done");
      final_report();
   end
endmodule : rtdcp_bank_test
